// File: rtl/csg_top.sv
// Card signal gating: card supply sequencer plus reset and clock gates.
// Assumes an analog supervisor reports card supply good on vcc_good_i and
// that host_clock_in_i is a free-running clock from the host.
//
// Overview of operation
// - With card active and supply good, card reset follows the host reset input.
// - Card reset held low when card inactive or supply too low.
// - With card active and supply good, card clock copies the host clock.
// - Card clock held low when card inactive or supply too low.
// - High level on the high-active detect input means a card is present.
// - Low level on the low-active detect input means a card is present.
// - Card supply is switched by the internal sequencer, never straight from pins.
// - Select code 00 1.8 V, 01 5.0 V, 10 3.0 V, 11 off.
// - Ready flag raised once the card supply is good after a select goes low.
`timescale 1ns/10ps
module csg_top
  import csg_pkg::*;
#(
  parameter int RAMP_LIMIT  = RAMP_CYC,
  parameter int DISCH_LIMIT = DISCH_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       host_clock_in_i,
  input  wire logic       host_reset_in_i,
  input  wire logic       supply_select_a_n_i,
  input  wire logic       supply_select_b_n_i,
  input  wire logic       card_detect_high_i,
  input  wire logic       card_detect_low_n_i,
  input  wire logic       vcc_good_i,
  output logic            card_rst_o,
  output logic            card_clk_o,
  output logic            vcc_en_o,
  output logic [1:0]      vcc_sel_o,
  output logic            ready_flag_o,
  output logic            card_present_o
);

  // ***********************************************
  // Elaboration checks
  // ***********************************************
  if (RAMP_LIMIT < 1 || RAMP_LIMIT >= (1 << CNT_W))
  begin : g_bad_ramp
    $error("RAMP_LIMIT out of range");
  end
  if (DISCH_LIMIT < 1 || DISCH_LIMIT >= (1 << CNT_W))
  begin : g_bad_disch
    $error("DISCH_LIMIT out of range");
  end

  localparam logic [CNT_W-1:0] RAMP_LAST  = CNT_W'(RAMP_LIMIT - 1);
  localparam logic [CNT_W-1:0] DISCH_LAST = CNT_W'(DISCH_LIMIT - 1);

  // ***********************************************
  // Reference domain: input synchronisers
  // ***********************************************
  logic [SYNC_REF_W-1:0] ref_s;
  logic [1:0]            sel_s;
  logic                  det_high_s;
  logic                  det_low_n_s;
  logic                  vcc_good_s;
  logic                  present;
  logic                  req;

  csg_sync #(
    .WIDTH     (SYNC_REF_W),
    .RESET_VAL (SYNC_REF_RST)
  ) u_sync_ref (
    .clk_i (ref_clk_i),
    .rst_i (rst_i),
    .d_i   ({vcc_good_i, card_detect_low_n_i, card_detect_high_i,
             supply_select_a_n_i, supply_select_b_n_i}),
    .q_o   (ref_s)
  );

  // Decode of filtered pins
  assign sel_s       = {ref_s[IDX_SEL_A], ref_s[IDX_SEL_B]};
  assign det_high_s  = ref_s[IDX_DET_HI];
  assign det_low_n_s = ref_s[IDX_DET_LO_N];
  assign vcc_good_s  = ref_s[IDX_VCC_GOOD];
  // Either detect polarity signals a card; unused input is tied inactive
  assign present     = det_high_s | ~det_low_n_s;
  // Any select low asks for the supply
  assign req         = (sel_s != SEL_OFF);

  // ***********************************************
  // Card supply sequencer
  // ***********************************************
  csg_state_t       state_r;
  csg_state_t       state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [1:0]       level_r;
  logic             gate_r;

  // Next state: supply follows the sequencer, pins only request it
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_OFF:
      begin
        cnt_nxt = '0;
        if (req && present)
          state_nxt = ST_RAMP;
      end
      ST_RAMP:
      begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (!req || !present || sel_s != level_r)
          state_nxt = ST_DOWN;
        else if (vcc_good_s)
          state_nxt = ST_ON;
        else if (cnt_r == RAMP_LAST)
          state_nxt = ST_DOWN;
        if (state_nxt != ST_RAMP)
          cnt_nxt = '0;
      end
      ST_ON:
      begin
        cnt_nxt = '0;
        // Card removal, supply fault or release of select drops the card
        if (!req || !present || !vcc_good_s || sel_s != level_r)
          state_nxt = ST_DOWN;
      end
      ST_DOWN:
      begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r == DISCH_LAST)
        begin
          state_nxt = ST_OFF;
          cnt_nxt   = '0;
        end
      end
      default:
      begin
        state_nxt = ST_DOWN;
        cnt_nxt   = '0;
      end
    endcase
  end

  // State and counter
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_OFF;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Selected level is caught at activation and held for the session
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      level_r <= SEL_OFF;
    else if (state_r == ST_OFF && state_nxt == ST_RAMP)
      level_r <= sel_s;
    else if (state_nxt == ST_OFF)
      level_r <= SEL_OFF;
  end

  // Registered outputs of the sequencer
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vcc_en_o       <= 1'b0;
      vcc_sel_o      <= SEL_OFF;
      ready_flag_o   <= 1'b0;
      gate_r         <= 1'b0;
      card_present_o <= 1'b0;
    end
    else
    begin
      vcc_en_o       <= (state_nxt == ST_RAMP) || (state_nxt == ST_ON);
      vcc_sel_o      <= (state_nxt == ST_OFF) ? SEL_OFF :
                        ((state_r == ST_OFF) ? sel_s : level_r);
      ready_flag_o   <= (state_nxt == ST_ON);
      gate_r         <= (state_nxt == ST_ON);
      card_present_o <= present;
    end
  end

  // ***********************************************
  // Link domain: card reset and clock gates
  // ***********************************************
  logic                   rst_link_a_r;
  logic                   rst_link_r;
  logic [SYNC_LINK_W-1:0] link_s;
  logic                   gate_l;
  logic                   host_rst_l;
  logic                   clk_en_r;

  // Reset asserts at once and releases on the link clock
  always_ff @(posedge host_clock_in_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_link_a_r <= 1'b1;
      rst_link_r   <= 1'b1;
    end
    else
    begin
      rst_link_a_r <= 1'b0;
      rst_link_r   <= rst_link_a_r;
    end
  end

  // Gate level and host reset pin both cross into the link clock
  csg_sync #(
    .WIDTH     (SYNC_LINK_W),
    .RESET_VAL (SYNC_LINK_RST)
  ) u_sync_link (
    .clk_i (host_clock_in_i),
    .rst_i (rst_link_r),
    .d_i   ({gate_r, host_reset_in_i}),
    .q_o   (link_s)
  );

  assign gate_l     = link_s[IDX_GATE];
  assign host_rst_l = link_s[IDX_HOST_RST];

  // Card reset passes the host level only while the card is live
  always_ff @(posedge host_clock_in_i or posedge rst_link_r)
  begin
    if (rst_link_r)
      card_rst_o <= 1'b0;
    else
      card_rst_o <= gate_l & host_rst_l;
  end

  // Enable changes on the falling edge so the gated clock cannot glitch
  always_ff @(negedge host_clock_in_i or posedge rst_link_r)
  begin
    if (rst_link_r)
      clk_en_r <= 1'b0;
    else
      clk_en_r <= gate_l;
  end

  // A copy of the clock cannot come from a flip-flop; the and-gate is a clock gate
  assign card_clk_o = host_clock_in_i & clk_en_r;

  // ***********************************************
  // Assertions
  // ***********************************************
  rst_follow_a: assert property (@(posedge host_clock_in_i) disable iff (rst_link_r)
    gate_l |=> (card_rst_o == $past(host_rst_l)))
    else $error("card reset does not follow host reset");

  rst_forced_a: assert property (@(posedge host_clock_in_i) disable iff (rst_link_r)
    !gate_l |=> !card_rst_o)
    else $error("card reset not forced low");

  // Sampled on the falling edge, where the gated clock is high if it runs at all
  clk_pass_a: assert property (@(negedge host_clock_in_i) disable iff (rst_link_r)
    gate_l ##1 gate_l |-> clk_en_r && card_clk_o)
    else $error("card clock not passed");

  clk_hold_a: assert property (@(negedge host_clock_in_i) disable iff (rst_link_r)
    !gate_l ##1 !gate_l |-> !clk_en_r && !card_clk_o)
    else $error("card clock not held low");

  det_high_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ST_OFF && req && det_high_s) |=> vcc_en_o && state_r == ST_RAMP)
    else $error("high detect did not start supply");

  det_low_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ST_OFF && req && !det_low_n_s) |=> vcc_en_o && state_r == ST_RAMP)
    else $error("low detect did not start supply");

  supply_seq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(vcc_en_o) |-> $past(state_r == ST_OFF && req && present))
    else $error("supply switched outside sequencer");

  ramp_bound_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ST_RAMP) |-> (cnt_r <= RAMP_LAST))
    else $error("ramp wait overran");

  level_map_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(vcc_en_o) |-> (vcc_sel_o == $past(sel_s)) && (vcc_sel_o != SEL_OFF))
    else $error("supply level does not match select pins");

  ready_rise_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(ready_flag_o) |-> $past(vcc_good_s && state_r == ST_RAMP) && vcc_en_o)
    else $error("ready without good supply");

  ready_drop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ready_flag_o && (!vcc_good_s || !present)) |=> !ready_flag_o ##1 !ready_flag_o)
    else $error("ready kept after fault");

endmodule

// File: rtl/csg_pkg.sv
// Constants shared by the card signal gating block.
// Assumes a 100 MHz reference clock; pin codes are as seen on the host side.
package csg_pkg;

  // ***********************************************
  // Clock and timing
  // ***********************************************
  localparam int CLK_PERIOD_NS  = 10;
  // Longest wait for the card supply to come good, rounded down
  localparam int RAMP_MAX_NS    = 10000;
  localparam int RAMP_CYC       = RAMP_MAX_NS / CLK_PERIOD_NS;
  // Least discharge time after switching the supply off, rounded up
  localparam int DISCH_MIN_NS   = 500;
  localparam int DISCH_CYC      = (DISCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 12;

  // ***********************************************
  // Supply select codes {a_n, b_n}
  // ***********************************************
  localparam logic [1:0] SEL_1V8 = 2'h0;
  localparam logic [1:0] SEL_5V0 = 2'h1;
  localparam logic [1:0] SEL_3V0 = 2'h2;
  localparam logic [1:0] SEL_OFF = 2'h3;

  // ***********************************************
  // Synchroniser layout
  // ***********************************************
  localparam int SYNC_REF_W     = 5;
  localparam int SYNC_LINK_W    = 2;
  // Idle pin levels: selects high, detect inputs inactive, supply not good,
  // so that leaving reset can never look like a request from a present card
  localparam logic [SYNC_REF_W-1:0]  SYNC_REF_RST  = 5'h0B;
  localparam logic [SYNC_LINK_W-1:0] SYNC_LINK_RST = 2'h0;
  localparam int IDX_SEL_B      = 0;
  localparam int IDX_SEL_A      = 1;
  localparam int IDX_DET_HI     = 2;
  localparam int IDX_DET_LO_N   = 3;
  localparam int IDX_VCC_GOOD   = 4;
  localparam int IDX_HOST_RST   = 0;
  localparam int IDX_GATE       = 1;

  // Card supply sequencer states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RAMP,
    ST_ON,
    ST_DOWN
  } csg_state_t;

endpackage

// File: rtl/csg_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_i; reset value is a constant.
`timescale 1ns/10ps
module csg_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // Stage one is read by stage two only, to keep metastability contained
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts once stages two and three agree, per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          q_o[g] <= RESET_VAL[g];
        else if (s2_r[g] == s3_r[g])
          q_o[g] <= s3_r[g];
      end
    end
  endgenerate

endmodule

// File: verification/csg_card_model.sv
// Card supply model: the supervisor's answer to the card supply enable.
// Assumes the bench drives slow_i and fail_i off the reference clock edge.
`timescale 1ns/10ps
module csg_card_model (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic vcc_en_i,
  input  wire logic slow_i,
  input  wire logic fail_i,
  output logic      vcc_good_o
);
  // ***********************************************
  // Supply ramp
  // ***********************************************
  logic [2:0] ramp_r;

  // Supply good a few cycles after enable; a slow card never gets there
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ramp_r <= 3'h0;
    else if (!vcc_en_i)
      ramp_r <= 3'h0;
    else if (ramp_r != 3'h5)
      ramp_r <= ramp_r + 3'h1;
  end

  // A commanded fault pulls good low at once, like a real supply droop
  assign vcc_good_o = (ramp_r == 3'h5) && !slow_i && !fail_i;
endmodule

// File: verification/card_signal_gating_test.sv
// Bench for the card signal gating block, self-checking.
// Assumes the supply model stands for the card supply supervisor.
`timescale 1ns/10ps
module card_signal_gating_test;
  logic ref_clk_i, rst_i, host_clk, host_rst, sel_a_n, sel_b_n, det_hi, det_lo_n;
  logic slow, fail, vcc_good;
  logic card_rst, card_clk, vcc_en, ready, present;
  logic [1:0] vcc_sel;
  int   fail_count, n_compared;

  // Small limits keep the run short; slow supply checks need DISCH_T of 2 or more
  localparam int RAMP_T  = 20;
  localparam int DISCH_T = 4;

  // Reference clock, 10 ns
  initial
  begin
    ref_clk_i = 0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Link clock, 12 ns, unrelated in phase to the reference clock
  initial
  begin
    host_clk = 0;
    #3;
    forever #6 host_clk = ~host_clk;
  end

  csg_top #(.RAMP_LIMIT(RAMP_T), .DISCH_LIMIT(DISCH_T)) dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_clock_in_i(host_clk),
    .host_reset_in_i(host_rst), .supply_select_a_n_i(sel_a_n),
    .supply_select_b_n_i(sel_b_n), .card_detect_high_i(det_hi),
    .card_detect_low_n_i(det_lo_n), .vcc_good_i(vcc_good), .card_rst_o(card_rst),
    .card_clk_o(card_clk), .vcc_en_o(vcc_en), .vcc_sel_o(vcc_sel),
    .ready_flag_o(ready), .card_present_o(present));

  csg_card_model model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .vcc_en_i(vcc_en),
    .slow_i(slow), .fail_i(fail), .vcc_good_o(vcc_good));

  // ***********************************************
  // Shared tasks
  // ***********************************************
  task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic drive(input logic [1:0] sel, input logic hi, input logic lo_n);
    @(negedge ref_clk_i);
    {sel_a_n, sel_b_n} = sel;
    det_hi = hi;
    det_lo_n = lo_n;
  endtask

  // Bounded wait, so a dead sequencer cannot hang the run
  task automatic wait_for(input logic v, input bit rdy);
    for (int i = 0; i < 40 && ((rdy ? ready : vcc_en) !== v); i++)
      @(negedge ref_clk_i);
  endtask

  task automatic link_wait();
    repeat (8) @(posedge host_clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic t_no_card();
    drive(2'h0, 1'b0, 1'b1);
    repeat (20) @(negedge ref_clk_i);
    check("enable without card", 2'h0, {1'b0, vcc_en});
    check("presence", 2'h0, {1'b0, present});
    drive(2'h3, 1'b0, 1'b1);
  endtask

  // Unused detect input held at its inactive level throughout
  task automatic t_activate(input logic [1:0] code, input logic use_lo);
    drive(code, !use_lo, !use_lo);
    wait_for(1'b1, 1'b0);
    check("selected level", code, vcc_sel);
    check("presence", 2'h1, {1'b0, present});
    wait_for(1'b1, 1'b1);
    check("ready", 2'h1, {1'b0, ready});
    host_rst = 1'b1;
    link_wait();
    check("card reset high", 2'h1, {1'b0, card_rst});
    @(negedge host_clk);
    #1;
    check("card clock low", 2'h0, {1'b0, card_clk});
    @(posedge host_clk);
    #1;
    check("card clock high", 2'h1, {1'b0, card_clk});
  endtask

  task automatic t_release(input string why);
    wait_for(1'b0, 1'b0);
    link_wait();
    check({why, " card reset"}, 2'h0, {1'b0, card_rst});
    check({why, " card clock"}, 2'h0, {1'b0, card_clk});
    check({why, " ready"}, 2'h0, {1'b0, ready});
    @(negedge host_clk);
    host_rst = 1'b0;
    drive(2'h3, 1'b0, 1'b1);
    repeat (12) @(negedge ref_clk_i);
    // Fault cleared only once the sequencer is idle, so no late ready pulse
    fail = 1'b0;
  endtask

  // Host reset drop is passed through while active, then the supply fails
  task automatic t_rst_drop();
    t_activate(2'h1, 1'b0);
    @(negedge host_clk);
    host_rst = 1'b0;
    link_wait();
    check("card reset low", 2'h0, {1'b0, card_rst});
    @(negedge host_clk);
    host_rst = 1'b1;
    fail = 1'b1;
    t_release("supply drop");
  endtask

  // Slow supply: the sequencer gives up after its ramp limit, not from the pins;
  // checked inside the discharge time, before it retries on its own
  task automatic t_slow_supply();
    slow = 1'b1;
    drive(2'h2, 1'b1, 1'b1);
    wait_for(1'b1, 1'b0);
    repeat (RAMP_T - 1) @(negedge ref_clk_i);
    check("slow supply still ramping", 2'h2, {vcc_en, ready});
    repeat (2) @(negedge ref_clk_i);
    check("slow supply enable", 2'h0, {vcc_en, ready});
    drive(2'h3, 1'b0, 1'b1);
    repeat (12) @(negedge ref_clk_i);
    slow = 1'b0;
  endtask

  initial
  begin
    rst_i = 1; host_rst = 0; sel_a_n = 1; sel_b_n = 1; det_hi = 0; det_lo_n = 1;
    slow = 0; fail = 0; fail_count = 0; n_compared = 0;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check("reset level code", 2'h3, vcc_sel);
    check("reset enable", 2'h0, {vcc_en, ready});
    rst_i = 0;
    t_no_card();
    // Every level code, one of them with the low-active detect input
    for (int c = 0; c < 3; c++)
    begin
      t_activate(c[1:0], c == 1);
      drive(2'h3, c != 1, c != 1);
      t_release("deselect");
    end
    t_rst_drop();
    t_slow_supply();
    print_verdict();
  end

  // Run needs about 3 us; a hang is cut short well past that
  initial
  begin
    #100us;
    fail_count++;
    print_verdict();
  end
endmodule
